/* verilog/aie_exec.sv */
// Decode and execute of the two byte-wide add instructions, APB reachable
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "aie_defs.svh"
module aie_exec (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [15:0] i_fsr2,
	output logic o_busy
);
	logic [7:0] dmem [0:4095];
	logic [15:0] instr_r, instr_nxt;
	logic [7:0] wreg_r, wreg_nxt;
	logic [4:0] flags_r, flags_nxt;
	logic [3:0] bank_select_reg_r, bank_select_reg_nxt;
	logic ext_r, ext_nxt;
	logic [11:0] dptr_r, dptr_nxt;
	logic [11:0] ea_r, ea_nxt;
	logic [7:0] opnd_r, opnd_nxt;
	logic [7:0] res_r, res_nxt;
	logic [4:0] rflg_r, rflg_nxt;
	logic bad_r, bad_nxt;
	aie_pkg::aie_phase_t phase_r, phase_nxt;
	aie_pkg::aie_kind_t kind_r, kind_nxt;
	logic wr_en, rd_en, go;
	logic [7:0] sum;
	logic [4:0] sflg;
	logic dm_we;
	logic [11:0] dm_wa;
	logic [7:0] dm_wd;

	// Effective address of a file operand: window, bank, or indexed
	function automatic logic [11:0] aie_ea(input logic [7:0] f, input logic a,
		input logic ext, input logic [3:0] bank, input logic [15:0] fsr2);
		logic [11:0] r;
		r = 12'h000;
		if (a) begin
			r = {bank, f};
		end else if (ext && f <= `AIE_IDX_LIMIT) begin
			r = fsr2[11:0] + {4'h0, f};
		end else if (f < `AIE_ACC_SPLIT) begin
			r = {4'h0, f};
		end else begin
			r = {`AIE_ACC_HIGH_BANK, f};
		end
		return r;
	endfunction

	assign wr_en = i_psel && i_penable && i_pwrite;
	assign rd_en = i_psel && !i_penable && !i_pwrite;
	assign go = wr_en && i_paddr == `AIE_REG_CTRL && i_pwdata[`AIE_CTRL_GO];
	assign o_pready = 1'b1; // Zero wait states, no stall ever
	assign o_pslverr = bad_r;
	assign o_busy = (kind_r != aie_pkg::AIE_KIND_NONE);

	aie_adder u_add (
		.i_a(wreg_r),
		.i_b(opnd_r),
		.o_sum(sum),
		.o_flags(sflg)
	);

	// Data memory write port, one byte per clock
	always_comb begin
		dm_we = 1'b0;
		dm_wa = dptr_r;
		dm_wd = i_pwdata[7:0];
		if (wr_en && i_paddr == `AIE_REG_DMEM_DATA) begin
			dm_we = 1'b1;
		end
		if (phase_r == aie_pkg::AIE_Q4 && kind_r == aie_pkg::AIE_KIND_FILE && instr_r[`AIE_DEST_BIT]) begin
			dm_we = 1'b1;
			dm_wa = ea_r;
			dm_wd = res_r;
		end
	end

	// Memory has no reset; it models register file contents
	always_ff @(posedge i_mclk) begin
		if (dm_we) begin
			dmem[dm_wa] <= dm_wd;
		end
	end

	// Instruction sequencer and software registers
	always_comb begin
		instr_nxt = instr_r;
		wreg_nxt = wreg_r;
		flags_nxt = flags_r;
		bank_select_reg_nxt = bank_select_reg_r;
		ext_nxt = ext_r;
		dptr_nxt = dptr_r;
		ea_nxt = ea_r;
		opnd_nxt = opnd_r;
		res_nxt = res_r;
		rflg_nxt = rflg_r;
		kind_nxt = kind_r;
		phase_nxt = phase_r;
		bad_nxt = 1'b0;
		// Software writes, accepted in every phase; only the Q4 result write to the accumulator, flags or file register overrides them
		if (wr_en) begin
			case (i_paddr)
				`AIE_REG_CTRL: ext_nxt = i_pwdata[`AIE_CTRL_EXT];
				`AIE_REG_INSTR: instr_nxt = i_pwdata[15:0];
				`AIE_REG_WREG: wreg_nxt = i_pwdata[7:0];
				`AIE_REG_STATUS: flags_nxt = i_pwdata[4:0];
				`AIE_REG_BANK: bank_select_reg_nxt = i_pwdata[3:0];
				`AIE_REG_DMEM_ADDR: dptr_nxt = i_pwdata[11:0];
				`AIE_REG_DMEM_DATA: dptr_nxt = dptr_r + 12'h001;
				default: bad_nxt = 1'b0; // Already refused in the setup cycle
			endcase
		end
		// Address check in the setup cycle, so the error stands in the access phase of reads and writes alike
		if (i_psel && !i_penable) begin
			case (i_paddr)
				`AIE_REG_CTRL, `AIE_REG_INSTR, `AIE_REG_WREG, `AIE_REG_STATUS,
				`AIE_REG_BANK, `AIE_REG_DMEM_ADDR, `AIE_REG_DMEM_DATA: bad_nxt = 1'b0;
				default: bad_nxt = 1'b1;
			endcase
		end
		case (phase_r)
			aie_pkg::AIE_Q1: begin
				// Decode; a start request is only taken between instructions
				if (kind_r == aie_pkg::AIE_KIND_NONE) begin
					if (go && instr_r[15:8] == `AIE_ADD_IMM_OP_HI) begin
						kind_nxt = aie_pkg::AIE_KIND_IMM;
						phase_nxt = aie_pkg::AIE_Q2;
					end else if (go && instr_r[15:10] == `AIE_ADD_FILE_OP_HI) begin
						kind_nxt = aie_pkg::AIE_KIND_FILE;
						ea_nxt = aie_ea(instr_r[7:0], instr_r[`AIE_BANK_BIT], ext_r, bank_select_reg_r, i_fsr2);
						phase_nxt = aie_pkg::AIE_Q2;
					end
				end
			end
			aie_pkg::AIE_Q2: begin
				// Read operand: literal or file register
				opnd_nxt = (kind_r == aie_pkg::AIE_KIND_IMM) ? instr_r[7:0] : dmem[ea_r];
				phase_nxt = aie_pkg::AIE_Q3;
			end
			aie_pkg::AIE_Q3: begin
				res_nxt = sum;
				rflg_nxt = sflg;
				phase_nxt = aie_pkg::AIE_Q4;
			end
			aie_pkg::AIE_Q4: begin
				// Write destination; flags always updated
				flags_nxt = rflg_r;
				if (kind_r == aie_pkg::AIE_KIND_IMM || !instr_r[`AIE_DEST_BIT]) begin
					wreg_nxt = res_r;
				end
				kind_nxt = aie_pkg::AIE_KIND_NONE;
				phase_nxt = aie_pkg::AIE_Q1;
			end
			default: phase_nxt = aie_pkg::AIE_Q1;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			instr_r <= 16'h0000;
			wreg_r <= 8'h00;
			flags_r <= 5'h00;
			bank_select_reg_r <= 4'h0;
			ext_r <= 1'b0;
			dptr_r <= 12'h000;
			ea_r <= 12'h000;
			opnd_r <= 8'h00;
			res_r <= 8'h00;
			rflg_r <= 5'h00;
			bad_r <= 1'b0;
			kind_r <= aie_pkg::AIE_KIND_NONE;
			phase_r <= aie_pkg::AIE_Q1;
		end else begin
			instr_r <= instr_nxt;
			wreg_r <= wreg_nxt;
			flags_r <= flags_nxt;
			bank_select_reg_r <= bank_select_reg_nxt;
			ext_r <= ext_nxt;
			dptr_r <= dptr_nxt;
			ea_r <= ea_nxt;
			opnd_r <= opnd_nxt;
			res_r <= res_nxt;
			rflg_r <= rflg_nxt;
			bad_r <= bad_nxt;
			kind_r <= kind_nxt;
			phase_r <= phase_nxt;
		end
	end

	// Read data registered in the setup cycle, valid in the access phase
	logic [31:0] rdata_r, rdata_nxt;
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_en) begin
			case (i_paddr)
				`AIE_REG_CTRL: rdata_nxt = {30'h0, ext_r, o_busy};
				`AIE_REG_INSTR: rdata_nxt = {16'h0000, instr_r};
				`AIE_REG_WREG: rdata_nxt = {24'h00_0000, wreg_r};
				`AIE_REG_STATUS: rdata_nxt = {27'h0, flags_r};
				`AIE_REG_BANK: rdata_nxt = {28'h000_0000, bank_select_reg_r};
				`AIE_REG_DMEM_ADDR: rdata_nxt = {20'h0_0000, dptr_r};
				`AIE_REG_DMEM_DATA: rdata_nxt = {24'h00_0000, dmem[dptr_r]};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign o_prdata = rdata_r;
endmodule

/* common/aie_defs.svh */
// Constants for the add instruction execution block
`ifndef AIE_DEFS_SVH
`define AIE_DEFS_SVH
// Opcode patterns on the upper bits of the instruction word
`define AIE_ADD_IMM_OP_HI 8'h0F
`define AIE_ADD_FILE_OP_HI 6'h09
// Field positions in the instruction word
`define AIE_DEST_BIT 9
`define AIE_BANK_BIT 8
// Indexed literal offset limit
`define AIE_IDX_LIMIT 8'h5F
// Access window split: offsets below 8'h60 in bank 0, from 8'h60 up in bank 15
`define AIE_ACC_SPLIT 8'h60
`define AIE_ACC_HIGH_BANK 4'hF
// Flag positions in the status output
`define AIE_FLG_C 0
`define AIE_FLG_DC 1
`define AIE_FLG_Z 2
`define AIE_FLG_OV 3
`define AIE_FLG_N 4
// APB register offsets
`define AIE_REG_CTRL 12'h000
`define AIE_REG_INSTR 12'h004
`define AIE_REG_WREG 12'h008
`define AIE_REG_STATUS 12'h00C
`define AIE_REG_BANK 12'h010
`define AIE_REG_DMEM_ADDR 12'h014
`define AIE_REG_DMEM_DATA 12'h018
// Control register bits, then the FSR2 reset value
`define AIE_CTRL_GO 0
`define AIE_CTRL_EXT 1
`define AIE_FSR2_RST 16'h0000
`endif

/* common/aie_pkg.sv */
// Types for the add instruction execution block
package aie_pkg;
	typedef enum logic [1:0] {
		AIE_Q1 = 2'b00,
		AIE_Q2 = 2'b01,
		AIE_Q3 = 2'b10,
		AIE_Q4 = 2'b11
	} aie_phase_t;
	typedef enum logic [1:0] {
		AIE_KIND_NONE = 2'b00,
		AIE_KIND_IMM = 2'b01,
		AIE_KIND_FILE = 2'b10
	} aie_kind_t;
endpackage

/* verilog/aie_adder.sv */
// Eight-bit adder with the five arithmetic flags
`timescale 1ns/1ps
`include "aie_defs.svh"
module aie_adder (
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	output logic [7:0] o_sum,
	output logic [4:0] o_flags
);
	logic [8:0] full;
	logic [4:0] low;
	// Flags follow the usual two's complement definitions
	always_comb begin
		full = {1'b0, i_a} + {1'b0, i_b};
		low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
		o_sum = full[7:0];
		o_flags = 5'h0_0;
		o_flags[`AIE_FLG_C] = full[8];
		o_flags[`AIE_FLG_DC] = low[4];
		o_flags[`AIE_FLG_Z] = (full[7:0] == 8'h00);
		o_flags[`AIE_FLG_OV] = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
		o_flags[`AIE_FLG_N] = full[7];
	end
endmodule

/* bench/aie_exec_assertions.sv */
// Port-level checks for the add execution block
`timescale 1ns/1ps
module aie_exec_assertions (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_busy
);
	logic [15:0] ins_r;
	logic [15:0] ins_nxt;
	logic wr;
	logic rs;
	logic go;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Track the last instruction word, so an ignored start is not taken for a real one
	always_comb begin
		wr = i_psel & i_penable & i_pwrite;
		rs = i_psel & !i_penable & !i_pwrite;
		ins_nxt = (wr && i_paddr == 12'h004) ? i_pwdata[15:0] : ins_r;
		go = wr & i_paddr == 12'h000 & i_pwdata[0] & !o_busy & (ins_r[15:8] == 8'h0F | ins_r[15:10] == 6'h09);
	end
	always_ff @(posedge i_mclk) begin
		ins_r <= i_rst_n ? ins_nxt : 16'h0000;
	end
	ready_high_a: assert property (o_pready) else $error("pready low");
	busy_run_a: assert property (go |=> o_busy [*3] ##1 !o_busy) else $error("busy span wrong");
	busy_cause_a: assert property ($rose(o_busy) |-> $past(go)) else $error("busy without start");
	bad_addr_a: assert property (i_psel && i_penable && i_paddr > 12'h018 |-> o_pslverr) else $error("no slverr");
	good_addr_a: assert property (i_psel && i_penable && i_paddr <= 12'h018 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
		else $error("false slverr");
	ctrl_busy_a: assert property (rs && i_paddr == 12'h000 |=> o_prdata[0] == $past(o_busy))
		else $error("busy bit wrong");
	flag_width_a: assert property (rs && i_paddr == 12'h00C |=> o_prdata[31:5] == 27'h0) else $error("flag bits");
	wreg_width_a: assert property (rs && i_paddr == 12'h008 |=> o_prdata[31:8] == 24'h0) else $error("wreg bits");
	cover property (go);
	cover property (o_pslverr);
	cover property ($fell(o_busy));
endmodule

/* bench/aie_exec_bench.sv */
// Self-checking bench for the add execution block
`timescale 1ns/1ps
module aie_exec_bench;
	typedef struct {logic [15:0] ins; logic [7:0] w; logic [7:0] m; logic [3:0] bank; logic ext; logic [11:0] loc;} aie_row_t;
	logic i_mclk = 1'h0, i_rst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
	logic o_pready, o_pslverr, o_busy, err;
	logic [15:0] i_fsr2 = 16'h0200;
	int failures = 0, cmp_count = 0;
	// Instruction, accumulator, file byte, bank, extended mode, resolved location
	aie_row_t rows[8] = '{'{16'h0F15, 8'h10, 8'h00, 4'h0, 1'h0, 12'h100}, '{16'h0F80, 8'h80, 8'h00, 4'h0, 1'h0, 12'h100},
		'{16'h2534, 8'h0C, 8'hF9, 4'h3, 1'h0, 12'h334}, '{16'h2708, 8'h7F, 8'h01, 4'h5, 1'h0, 12'h508},
		'{16'h2420, 8'h2A, 8'h08, 4'h0, 1'h0, 12'h020}, '{16'h2680, 8'h11, 8'h22, 4'h9, 1'h0, 12'hF80},
		'{16'h265F, 8'h33, 8'h44, 4'h9, 1'h1, 12'h25F}, '{16'h2660, 8'h55, 8'h66, 4'h9, 1'h1, 12'hF60}};
	aie_exec u_aie_exec (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_fsr2(i_fsr2), .o_busy(o_busy));
	// Free-running core clock
	initial begin
		forever #2 i_mclk = ~i_mclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'h1;
		@(posedge i_mclk);
		while (o_pready !== 1'h1) @(posedge i_mclk);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask
	task automatic start(input logic [15:0] ins, input logic [31:0] ctl);
		apb(1'h1, 12'h004, 32'(ins));
		apb(1'h1, 12'h000, ctl);
	endtask
	task automatic run(input aie_row_t r);
		logic [8:0] s;
		logic [7:0] b;
		logic dst;
		b = (r.ins[15:8] == 8'h0F) ? r.ins[7:0] : r.m;
		s = r.w + b;
		dst = r.ins[13] & r.ins[9];
		apb(1'h1, 12'h000, 32'({r.ext, 1'h0}));
		apb(1'h1, 12'h010, 32'(r.bank));
		apb(1'h1, 12'h008, 32'(r.w));
		apb(1'h1, 12'h014, 32'(r.loc));
		apb(1'h1, 12'h018, 32'(r.m));
		start(r.ins, 32'({r.ext, 1'h1}));
		@(posedge i_mclk);
		#1;
		while (o_busy !== 1'h0) @(posedge i_mclk);
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk("wreg", rd, 32'(dst ? r.w : s[7:0]));
		apb(1'h0, 12'h00C, 32'h0000_0000);
		chk("status", rd, 32'({s[7], r.w[7] == b[7] && s[7] != r.w[7], s[7:0] == 8'h00, s[4] ^ r.w[4] ^ b[4], s[8]}));
		apb(1'h1, 12'h014, 32'(r.loc));
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk("file byte", rd, 32'(dst ? s[7:0] : r.m));
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard, several times the expected run length
	initial begin
		#20000;
		failures++;
		close_out;
	end
	// Reset, table rows, then the awkward cases
	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		apb(1'h0, 12'h000, 32'h0000_0000);
		chk("ctrl reset", rd, 32'h0000_0000);
		foreach (rows[i]) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		apb(1'h1, 12'h01C, 32'h0000_00FF);
		chk("unmapped err", 32'(err), 32'h0000_0001);
		apb(1'h0, 12'h01C, 32'h0000_0000);
		chk("unmapped read err", 32'(err), 32'h0000_0001);
		chk("unmapped read data", rd, 32'h0000_0000);
		apb(1'h0, 12'h002, 32'h0000_0000);
		chk("misaligned err", 32'(err), 32'h0000_0001);
		$display("unmapped tests done");
		start(16'h2000, 32'h0000_0001);
		@(posedge i_mclk);
		#1;
		chk("foreign opcode", 32'(o_busy), 32'h0000_0000);
		start(16'h0F01, 32'h0000_0001);
		apb(1'h0, 12'h000, 32'h0000_0000);
		chk("busy seen", rd, 32'h0000_0001);
		$display("hand tests done");
		// Reset right after a start must abandon the instruction in flight
		start(16'h0F02, 32'h0000_0001);
		i_rst_n <= 1'h0;
		@(posedge i_mclk);
		i_rst_n <= 1'h1;
		apb(1'h0, 12'h000, 32'h0000_0000);
		chk("ctrl after reset", rd, 32'h0000_0000);
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk("wreg after reset", rd, 32'h0000_0000);
		$display("reset test done");
		close_out;
	end
endmodule
bind aie_exec aie_exec_assertions u_aie_exec_assertions (.*);
